/* File: common/preamble_pkg.sv */
// package for the receive preamble qualification block
package preamble_pkg;
    localparam int THRESH_W = 7;
    localparam logic [6:0] THRESH_RESET = 7'h14;
    localparam int PATTERN_W = 32;
    localparam logic [31:0] PATTERN_RESET = 32'hAAAAAAAA;
    localparam logic [5:0] PATTERN_LEN_RESET = 6'h10;
    localparam int ARRIVAL_BYTE_BITS = 8;
    localparam int ARRIVAL_AFC_BITS = 16;
    localparam logic [1:0] ARCH_FIXED_IF = 2'h0;
    localparam logic [1:0] ARCH_ZERO_IF = 2'h1;
    localparam logic [1:0] ARCH_SCALED_IF = 2'h2;

    typedef enum logic [1:0] {
        DET_TRADITIONAL,
        DET_NONSTANDARD,
        DET_ARRIVAL
    } detector_sel_t;

    typedef struct packed {
        logic [6:0] preambleThreshold;
    } standard_lead_in_settings_t;

    typedef struct packed {
        logic [5:0] patternLen;
        logic [5:0] repeatsNeeded;
        logic [31:0] pattern;
    } nonstandard_lead_in_settings_t;

    typedef struct packed {
        logic valid;
        logic bit_;
    } rx_bit_t;
endpackage

/* File: src/rx_preamble_detector.sv */
// preamble qualification: alternation counter, pattern matcher, signal-arrival gate
//
// Contract
// - alternating-bit counter reaching threshold declares the standard preamble valid
// - sync search enable only asserts after a preamble is qualified
// - any detection, even false, starts remainder search; new preambles ignored meanwhile
// - threshold applies only to alternating pattern; nonstandard uses its own settings
// - arrival detector can declare a preamble within one byte
// - with frequency correction, arrival detection and one-shot correction within two bytes
// - arrival detector shares the jump detector; software may reconfigure it afterwards
// - traditional detector stays selectable beside the arrival detector
// - nonstandard type works for any pattern, alternating included
// - receive architecture selects fixed-, zero- or scaled-IF, fixed-IF after reset
`timescale 1ns/1ps
module rx_preamble_detector
    import preamble_pkg::*;
#(
    parameter int PAT_W = PATTERN_W
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire rx_bit_t rxBit,
    input wire logic jumpDetected,
    input wire detector_sel_t detectorSel,
    input wire standard_lead_in_settings_t standardLeadInSettings,
    input wire nonstandard_lead_in_settings_t nonstandardLeadInSettings,
    input wire logic afcEnable,
    input wire logic [1:0] rxArchSel,
    input wire logic remainderDone,
    output logic preambleValid,
    output logic preambleDetectPulse,
    output logic syncSearchEnable,
    output logic afcOneShot,
    output logic [1:0] rxArchitecture
);
    logic prevBit_reg;
    logic havePrev_reg;
    logic [6:0] altCount_reg;
    logic [6:0] altCount_next;
    logic [PAT_W-1:0] shift_reg;
    logic [5:0] bitsSeen_reg;
    logic [5:0] repeatCount_reg;
    logic [4:0] arrivalBits_reg;
    logic arrivalArmed_reg;
    logic searching_reg;

    // the alternation check compares against the last bit only
    wire logic alternates = havePrev_reg && (rxBit.bit_ != prevBit_reg);
    wire logic [6:0] threshold = standardLeadInSettings.preambleThreshold;
    assign altCount_next = alternates ?
        ((altCount_reg == 7'h7F) ? altCount_reg : altCount_reg + 7'h01) : 7'h00;
    // the threshold counts bits of the run, so the bit that opens the run counts too
    wire logic [7:0] runLen = {1'b0, altCount_next} + 8'h01;

    // standard hit: the run reaches the threshold on this bit
    wire logic stdHit = rxBit.valid && (detectorSel == DET_TRADITIONAL)
        && (threshold != 7'h00) && (runLen >= {1'b0, threshold});

    // nonstandard: compare the newest patternLen bits against the expected pattern
    wire logic [PAT_W-1:0] shifted = {shift_reg[PAT_W-2:0], rxBit.bit_};
    wire logic [PAT_W-1:0] patMask;
    for (genvar g = 0; g < PAT_W; g++) begin : g_mask
        assign patMask[g] = (g < int'(nonstandardLeadInSettings.patternLen));
    end
    wire logic [PAT_W-1:0] expected = PAT_W'(nonstandardLeadInSettings.pattern);
    wire logic patMatch = ((shifted ^ expected) & patMask) == '0;
    wire logic [5:0] bitsSeenInc = (bitsSeen_reg == 6'h3F) ? bitsSeen_reg : bitsSeen_reg + 6'h01;
    wire logic patWindowFull = (bitsSeenInc >= nonstandardLeadInSettings.patternLen);
    wire logic patBoundary = patWindowFull && patMatch;
    // saturate so a long idle stretch in another mode cannot wrap back to a small count
    wire logic [5:0] repeatInc = (repeatCount_reg == 6'h3F) ? repeatCount_reg
        : repeatCount_reg + 6'h01;
    // any pattern, alternating included, is accepted here
    wire logic nstdHit = rxBit.valid && (detectorSel == DET_NONSTANDARD) && patBoundary
        && (repeatInc >= nonstandardLeadInSettings.repeatsNeeded);

    // arrival: jump seen, then one byte (two with frequency correction) of bits
    wire logic [4:0] arrivalNeed = afcEnable ? 5'(ARRIVAL_AFC_BITS) : 5'(ARRIVAL_BYTE_BITS);
    wire logic [4:0] arrivalBitsInc = (arrivalBits_reg == 5'h1F) ? arrivalBits_reg
        : arrivalBits_reg + 5'h01;
    wire logic arrivalHit = rxBit.valid && (detectorSel == DET_ARRIVAL) && arrivalArmed_reg
        && (arrivalBitsInc >= arrivalNeed);

    // while searching for the rest of a packet, fresh detections are not taken
    wire logic detect = !searching_reg && (stdHit || nstdHit || arrivalHit);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prevBit_reg <= 1'b0;
            havePrev_reg <= 1'b0;
            altCount_reg <= 7'h00;
        end else if (detect || searching_reg) begin
            havePrev_reg <= 1'b0;
            altCount_reg <= 7'h00;
        end else if (rxBit.valid) begin
            prevBit_reg <= rxBit.bit_;
            havePrev_reg <= 1'b1;
            altCount_reg <= altCount_next;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= '0;
            bitsSeen_reg <= 6'h00;
            repeatCount_reg <= 6'h00;
        end else if (detect || searching_reg) begin
            bitsSeen_reg <= 6'h00;
            repeatCount_reg <= 6'h00;
        end else if (rxBit.valid) begin
            shift_reg <= shifted;
            if (patBoundary) begin
                bitsSeen_reg <= 6'h00;
                repeatCount_reg <= repeatInc;
            end else begin
                bitsSeen_reg <= bitsSeenInc;
                if (patWindowFull) begin
                    repeatCount_reg <= 6'h00;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            arrivalArmed_reg <= 1'b0;
            arrivalBits_reg <= 5'h00;
        end else if (detect || searching_reg) begin
            arrivalArmed_reg <= 1'b0;
            arrivalBits_reg <= 5'h00;
        end else if (jumpDetected) begin
            arrivalArmed_reg <= 1'b1;
            arrivalBits_reg <= 5'h00;
        end else if (rxBit.valid && arrivalArmed_reg) begin
            arrivalBits_reg <= arrivalBitsInc;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            searching_reg <= 1'b0;
            preambleValid <= 1'b0;
            preambleDetectPulse <= 1'b0;
            syncSearchEnable <= 1'b0;
            afcOneShot <= 1'b0;
        end else begin
            preambleDetectPulse <= detect;
            afcOneShot <= detect && afcEnable;
            if (detect) begin
                searching_reg <= 1'b1;
                preambleValid <= 1'b1;
                syncSearchEnable <= 1'b1;
            end else if (remainderDone) begin
                searching_reg <= 1'b0;
                preambleValid <= 1'b0;
                syncSearchEnable <= 1'b0;
            end
        end
    end

    // reserved code falls back to fixed-IF
    wire logic [1:0] archNext = (rxArchSel == 2'h3) ? ARCH_FIXED_IF : rxArchSel;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rxArchitecture <= ARCH_FIXED_IF;
        end else begin
            rxArchitecture <= archNext;
        end
    end

    // ---- checks
    property p_sync_needs_detect;
        @(posedge mclk) disable iff (!arst_n)
        $rose(syncSearchEnable) |-> $past(detect);
    endproperty
    a_sync_needs_detect: assert property (p_sync_needs_detect) else $error("sync search without preamble");

    property p_std_threshold;
        @(posedge mclk) disable iff (!arst_n)
        (stdHit && !searching_reg) |=> preambleValid && preambleDetectPulse;
    endproperty
    a_std_threshold: assert property (p_std_threshold) else $error("threshold reached, no detect");

    property p_no_early_std;
        @(posedge mclk) disable iff (!arst_n)
        (detectorSel == DET_TRADITIONAL && rxBit.valid && !searching_reg
            && runLen < {1'b0, threshold}) |=> !preambleDetectPulse;
    endproperty
    a_no_early_std: assert property (p_no_early_std) else $error("detect below threshold");

    property p_restart;
        @(posedge mclk) disable iff (!arst_n)
        (rxBit.valid && havePrev_reg && rxBit.bit_ == prevBit_reg) |=> altCount_reg == 7'h00;
    endproperty
    a_restart: assert property (p_restart) else $error("counter kept on repeated bit");

    property p_hold_search;
        @(posedge mclk) disable iff (!arst_n)
        (searching_reg && !remainderDone) |=> searching_reg && !preambleDetectPulse;
    endproperty
    a_hold_search: assert property (p_hold_search) else $error("search dropped or redetected");

    property p_arrival_byte;
        @(posedge mclk) disable iff (!arst_n)
        (detectorSel == DET_ARRIVAL && !afcEnable && arrivalArmed_reg && rxBit.valid
            && arrivalBits_reg == 5'h07 && !searching_reg) |=> preambleDetectPulse;
    endproperty
    a_arrival_byte: assert property (p_arrival_byte) else $error("arrival not within a byte");

    property p_afc_shot;
        @(posedge mclk) disable iff (!arst_n)
        preambleDetectPulse |-> (afcOneShot == $past(afcEnable));
    endproperty
    a_afc_shot: assert property (p_afc_shot) else $error("one-shot correction mismatch");

    property p_arch;
        @(posedge mclk) disable iff (!arst_n)
        (rxArchSel != 2'h3) |=> rxArchitecture == $past(rxArchSel);
    endproperty
    a_arch: assert property (p_arch) else $error("architecture not applied");

    property p_pulse_one;
        @(posedge mclk) disable iff (!arst_n)
        preambleDetectPulse |=> !preambleDetectPulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("detect pulse too long");

    // search window: outputs rise with the detect pulse and drop on remainderDone
    property p_pulse_sets_valid;
        @(posedge mclk) disable iff (!arst_n)
        preambleDetectPulse |-> preambleValid && syncSearchEnable;
    endproperty
    a_pulse_sets_valid: assert property (p_pulse_sets_valid) else $error("pulse without valid");

    property p_search_ends;
        @(posedge mclk) disable iff (!arst_n)
        (searching_reg && remainderDone) |=> !preambleValid && !syncSearchEnable;
    endproperty
    a_search_ends: assert property (p_search_ends) else $error("search not ended");

    property p_refused;
        @(posedge mclk) disable iff (!arst_n)
        searching_reg |=> !havePrev_reg && altCount_reg == 7'h00 && bitsSeen_reg == 6'h00
            && !arrivalArmed_reg;
    endproperty
    a_refused: assert property (p_refused) else $error("counting while searching");

    property p_threshold_zero;
        @(posedge mclk) disable iff (!arst_n)
        (detectorSel == DET_TRADITIONAL && threshold == 7'h00) |=> !preambleDetectPulse;
    endproperty
    a_threshold_zero: assert property (p_threshold_zero) else $error("detect at zero threshold");

    // pattern matcher ignores the alternation threshold
    property p_nstd_hit;
        @(posedge mclk) disable iff (!arst_n)
        (nstdHit && !searching_reg) |=> preambleDetectPulse;
    endproperty
    a_nstd_hit: assert property (p_nstd_hit) else $error("pattern matched, no detect");

    property p_nstd_boundary;
        @(posedge mclk) disable iff (!arst_n)
        (detectorSel == DET_NONSTANDARD && !patBoundary) |=> !preambleDetectPulse;
    endproperty
    a_nstd_boundary: assert property (p_nstd_boundary) else $error("pattern detect off boundary");

    property p_arrival_afc;
        @(posedge mclk) disable iff (!arst_n)
        (detectorSel == DET_ARRIVAL && afcEnable && arrivalArmed_reg && rxBit.valid
            && arrivalBits_reg == 5'h0F && !searching_reg) |=> preambleDetectPulse;
    endproperty
    a_arrival_afc: assert property (p_arrival_afc) else $error("arrival not within two bytes");

    property p_arrival_early;
        @(posedge mclk) disable iff (!arst_n)
        (detectorSel == DET_ARRIVAL && arrivalBitsInc < arrivalNeed) |=> !preambleDetectPulse;
    endproperty
    a_arrival_early: assert property (p_arrival_early) else $error("arrival detect too early");

    property p_arrival_armed;
        @(posedge mclk) disable iff (!arst_n)
        (detectorSel == DET_ARRIVAL && !arrivalArmed_reg) |=> !preambleDetectPulse;
    endproperty
    a_arrival_armed: assert property (p_arrival_armed) else $error("arrival without jump");

    property p_shot_in_pulse;
        @(posedge mclk) disable iff (!arst_n)
        afcOneShot |-> preambleDetectPulse;
    endproperty
    a_shot_in_pulse: assert property (p_shot_in_pulse) else $error("one-shot without detect");

    property p_arch_reserved;
        @(posedge mclk) disable iff (!arst_n)
        (rxArchSel == 2'h3) |=> rxArchitecture == ARCH_FIXED_IF;
    endproperty
    a_arch_reserved: assert property (p_arch_reserved) else $error("reserved code not fixed-IF");

    c_std: cover property (@(posedge mclk) disable iff (!arst_n)
        preambleDetectPulse && detectorSel == DET_TRADITIONAL);
    c_nstd: cover property (@(posedge mclk) disable iff (!arst_n)
        preambleDetectPulse && detectorSel == DET_NONSTANDARD);
    c_arr: cover property (@(posedge mclk) disable iff (!arst_n)
        preambleDetectPulse && detectorSel == DET_ARRIVAL && afcEnable);
    c_end: cover property (@(posedge mclk) disable iff (!arst_n)
        searching_reg && remainderDone);
endmodule

/* File: tb/lead_in_sender.sv */
// behavioural remote transmitter that sends demodulated lead-in bits
`timescale 1ns/1ps
module lead_in_sender
    import preamble_pkg::*;
(
    input wire logic mclk,
    output rx_bit_t rxBit
);
    initial rxBit = '{valid: 1'b0, bit_: 1'b0};

    // bits go out msb first, back to back, one per clock
    task automatic send(input int n, input logic [31:0] bits);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge mclk);
            rxBit.valid = 1'b1;
            rxBit.bit_ = bits[i];
        end
        @(negedge mclk);
        rxBit.valid = 1'b0;
        // idle line shows the inverse so a stale bit never looks valid
        rxBit.bit_ = ~bits[0];
    endtask
endmodule

/* File: tb/tb_rx_preamble_detector.sv */
// self-checking bench for the receive preamble qualification block
`timescale 1ns/1ps
module tb_rx_preamble_detector
    import preamble_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    rx_bit_t rxBit;
    logic jumpDetected = 1'b0;
    detector_sel_t detectorSel = DET_TRADITIONAL;
    standard_lead_in_settings_t stdSet = '{preambleThreshold: THRESH_RESET};
    nonstandard_lead_in_settings_t nstdSet = '{6'h08, 6'h01, 32'h000000AA};
    logic afcEnable = 1'b0;
    logic [1:0] rxArchSel = 2'h0;
    logic remainderDone = 1'b0;
    logic preambleValid, preambleDetectPulse, syncSearchEnable, afcOneShot;
    logic [1:0] rxArchitecture;
    int badCount = 0;
    int checksDone = 0;
    int pulses = 0;
    int shots = 0;
    int cycles = 0;

    rx_preamble_detector dut (.mclk(mclk), .arst_n(arst_n), .rxBit(rxBit),
        .jumpDetected(jumpDetected), .detectorSel(detectorSel),
        .standardLeadInSettings(stdSet), .nonstandardLeadInSettings(nstdSet),
        .afcEnable(afcEnable), .rxArchSel(rxArchSel), .remainderDone(remainderDone),
        .preambleValid(preambleValid), .preambleDetectPulse(preambleDetectPulse),
        .syncSearchEnable(syncSearchEnable), .afcOneShot(afcOneShot),
        .rxArchitecture(rxArchitecture));
    lead_in_sender tx (.mclk(mclk), .rxBit(rxBit));

    initial begin
        forever #20 mclk = ~mclk;
    end

    // pulses are counted at the edge after they land, so width errors show up
    always @(posedge mclk) begin
        if (preambleDetectPulse === 1'b1) pulses++;
        if (afcOneShot === 1'b1) shots++;
        cycles++;
        if (cycles == 3000) begin
            badCount++;
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask

    task automatic endSearch();
        @(negedge mclk);
        remainderDone = 1'b1;
        @(negedge mclk);
        remainderDone = 1'b0;
        settle();
        check(preambleValid, 1'b0);
        check(syncSearchEnable, 1'b0);
    endtask

    task automatic testArch();
        check(rxArchitecture, ARCH_FIXED_IF);
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            rxArchSel = 2'(i);
            settle();
            check(rxArchitecture, (i == 3) ? ARCH_FIXED_IF : 2'(i));
        end
        $display("test arch done");
    endtask

    task automatic testArrival(input logic afc);
        detectorSel = DET_ARRIVAL;
        afcEnable = afc;
        pulses = 0;
        shots = 0;
        @(negedge mclk);
        jumpDetected = 1'b1;
        @(negedge mclk);
        jumpDetected = 1'b0;
        tx.send(afc ? 15 : 7, 32'h00005555);
        settle();
        check(preambleValid, 1'b0);
        tx.send(1, 32'h0);
        settle();
        check(preambleValid, 1'b1);
        check(pulses, 1);
        check(shots, 32'(afc));
        endSearch();
        afcEnable = 1'b0;
        $display("test arrival done");
    endtask

    task automatic testTraditional();
        detectorSel = DET_TRADITIONAL;
        stdSet.preambleThreshold = 7'h02;
        pulses = 0;
        tx.send(1, 32'h1);
        settle();
        check(preambleValid, 1'b0);
        tx.send(1, 32'h0);
        settle();
        check(preambleValid, 1'b1);
        check(syncSearchEnable, 1'b1);
        tx.send(8, 32'hAA);
        settle();
        check(pulses, 1);
        endSearch();
        stdSet.preambleThreshold = 7'h04;
        tx.send(6, 32'h2D);
        settle();
        check(preambleValid, 1'b0);
        tx.send(1, 32'h0);
        settle();
        check(preambleValid, 1'b1);
        endSearch();
        $display("test traditional done");
    endtask

    task automatic testThreshold();
        detectorSel = DET_TRADITIONAL;
        stdSet.preambleThreshold = THRESH_RESET;
        pulses = 0;
        // four-byte lead-in: one bit short of the threshold, the last bit, then the rest
        tx.send(int'(THRESH_RESET) - 1, 32'h00055555);
        settle();
        check(preambleValid, 1'b0);
        tx.send(1, 32'h0);
        settle();
        check(preambleValid, 1'b1);
        tx.send(32 - int'(THRESH_RESET), 32'h00000AAA);
        settle();
        check(pulses, 1);
        endSearch();
        // zero threshold leaves qualification to a long sync word
        stdSet.preambleThreshold = 7'h00;
        tx.send(32, 32'hAAAAAAAA);
        settle();
        check(preambleValid, 1'b0);
        check(pulses, 1);
        $display("test threshold done");
    endtask

    task automatic testNonstandard();
        detectorSel = DET_NONSTANDARD;
        stdSet.preambleThreshold = 7'h02;
        tx.send(7, 32'h55);
        settle();
        check(preambleValid, 1'b0);
        tx.send(1, 32'h0);
        settle();
        check(preambleValid, 1'b1);
        endSearch();
        $display("test nonstandard done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge mclk);
        check(preambleValid, 1'b0);
        arst_n = 1'b1;
        testArch();
        testArrival(1'b0);
        testArrival(1'b1);
        testTraditional();
        testThreshold();
        testNonstandard();
        results();
    end
endmodule
